// file: design/qdac_fifo.sv
`timescale 1ns/1ns
module qdac_fifo #(parameter int W = 14, parameter int DEPTH = 8)
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Both stream sides
    qdac_stream_if.fifo s
);

    // DEPTH must be a power of two so the pointers wrap cleanly
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem_reg [DEPTH];
    logic [AW:0]   wr_ptr_reg;
    logic [AW:0]   rd_ptr_reg;
    logic [AW:0]   fill;
    logic          push_fire;
    logic          pop_fire;

    // Occupancy from the extra pointer bit gives honest full and empty
    assign fill         = wr_ptr_reg - rd_ptr_reg;
    assign s.push_ready = (fill != (AW+1)'(DEPTH));
    assign s.pop_valid  = (fill != '0);
    assign s.pop_data   = mem_reg[rd_ptr_reg[AW-1:0]];
    assign push_fire    = s.push_valid & s.push_ready;
    assign pop_fire     = s.pop_valid & s.pop_ready;

    // Storage writes
    always_ff @(posedge clk_i)
    begin
        if (push_fire)
            mem_reg[wr_ptr_reg[AW-1:0]] <= s.push_data;
    end

    // Pointers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end
        else
        begin
            if (push_fire)
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop_fire)
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
    end

endmodule

// file: design/qdac_serial_load.sv
`timescale 1ns/1ns
`include "qdac_params.svh"
module qdac_serial_load
    import qdac_pkg::*;
#(
    parameter int ADDR_W     = 8,
    parameter int FIFO_DEPTH = `QDAC_FIFO_DEPTH
)
(
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // AXI4-Lite write address and data
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Serial link pins
    input  wire logic              frame_sync_n_i,
    input  wire logic              serial_clk_in_i,
    input  wire logic              serial_data_in_i,
    output logic                   serial_data_out_o,
    // Latch control and address strap pins
    input  wire logic              load_all_outputs_n_i,
    input  wire logic              zero_outputs_n_i,
    input  wire logic              addr_strap_lo_i,
    input  wire logic              addr_strap_hi_i,
    // Converter switch drive
    output logic [47:0]            dac_code_o,
    output logic [11:0]            seg_switch_o,
    output logic [39:0]            ladder_switch_o
);

    import qdac_pkg::*;

    localparam int NCH = `QDAC_NUM_CH;
    localparam int WB  = `QDAC_WORD_BITS;

    // Word indices of the registers, at the width of the decoded address slice
    localparam logic [ADDR_W-3:0] IX_CTRL  = (ADDR_W-2)'(`QDAC_OFS_CTRL >> 2);
    localparam logic [ADDR_W-3:0] IX_STAT  = (ADDR_W-2)'(`QDAC_OFS_STATUS >> 2);
    localparam logic [ADDR_W-3:0] IX_WORDS = (ADDR_W-2)'(`QDAC_OFS_WORDS >> 2);
    localparam logic [ADDR_W-3:0] IX_INL   = (ADDR_W-2)'(`QDAC_OFS_INL_BASE >> 2);
    localparam logic [ADDR_W-3:0] IX_DACL  = (ADDR_W-2)'(`QDAC_OFS_DACL_BASE >> 2);

    // Synchronised pins
    logic [6:0]        pins_s;
    logic              frame_n_s;
    logic              sclk_s;
    logic              sdata_s;
    logic              load_n_s;
    logic              clr_n_s;
    logic              strap_lo_s;
    logic              strap_hi_s;
    logic              sclk_prev_reg;
    logic              load_n_prev_reg;
    logic              sclk_fall;
    logic              load_fall;

    // Serial front end
    logic [WB-1:0]     shift_reg;
    logic [WB-1:0]     word_next;
    logic [4:0]        bit_cnt_reg;
    logic              word_done;
    logic              addr_match;

    // Latches and stream
    qdac_word_s        acc_word_reg;
    logic              acc_valid_reg;
    qdac_word_s        pop_word;
    qdac_code_t        inl_reg  [NCH];
    qdac_code_t        dacl_reg [NCH];
    logic [47:0]       code_reg;
    logic [11:0]       seg_reg;
    logic [39:0]       ladder_reg;

    // Software state
    logic [31:0]       ctrl_reg;
    logic              ovf_reg;
    logic [15:0]       acc_cnt_reg;
    logic [15:0]       rej_cnt_reg;

    // Bus slave state
    logic              aw_got_reg;
    logic              w_got_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [31:0]       w_data_reg;
    logic [3:0]        w_strb_reg;
    logic              wr_do;
    logic              wr_hit;
    logic              ovf_clr;
    logic [31:0]       rd_data;
    logic              rd_hit;

    qdac_stream_if #(.W($bits(qdac_word_s))) strm ();

    // Every pin comes from outside this clock domain
    qdac_sync #(.W(7)) u_sync
    (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i ({frame_sync_n_i, serial_clk_in_i, serial_data_in_i, load_all_outputs_n_i,
                   zero_outputs_n_i, addr_strap_lo_i, addr_strap_hi_i}),
        .sync_o  (pins_s)
    );

    assign frame_n_s  = pins_s[6];
    assign sclk_s     = pins_s[5];
    assign sdata_s    = pins_s[4];
    assign load_n_s   = pins_s[3];
    assign clr_n_s    = pins_s[2];
    assign strap_lo_s = pins_s[1];
    assign strap_hi_s = pins_s[0];

    // Edge detectors track the synchronised levels even in reset, so the
    // synchroniser flushing out of its reset state never looks like an edge
    always_ff @(posedge clk_i)
    begin
        sclk_prev_reg   <= sclk_s;
        load_n_prev_reg <= load_n_s;
    end

    assign sclk_fall = sclk_prev_reg & ~sclk_s;
    assign load_fall = load_n_prev_reg & ~load_n_s;

    // Shifter runs at every falling edge in a frame, whatever the address
    assign word_next = {shift_reg[WB-2:0], sdata_s};

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            shift_reg <= '0;
        else if (sclk_fall && !frame_n_s)
            shift_reg <= word_next;
    end

    assign serial_data_out_o = shift_reg[WB-1];

    // Bit counter restarts at every frame and stops after the sixteenth edge
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            bit_cnt_reg <= '0;
        else if (frame_n_s)
            bit_cnt_reg <= '0;
        else if (sclk_fall && bit_cnt_reg != 5'(WB))
            bit_cnt_reg <= bit_cnt_reg + 5'h1;
    end

    // Longer frames still pass bits on, but only the first word is decoded here
    assign word_done  = sclk_fall && !frame_n_s && (bit_cnt_reg == 5'(WB - 1));
    assign addr_match = (word_next[`QDAC_ADDR_HI_BIT] == strap_hi_s)
                     && (word_next[`QDAC_ADDR_LO_BIT] == strap_lo_s);

    // Accepted word, offered to the FIFO for one cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            acc_valid_reg <= 1'b0;
            acc_word_reg  <= '0;
        end
        else
        begin
            acc_valid_reg <= word_done && addr_match && ctrl_reg[`QDAC_CTRL_LISTEN_BIT];
            if (word_done)
            begin
                acc_word_reg.code <= word_next[`QDAC_CODE_MSB:`QDAC_CODE_LSB];
                acc_word_reg.chan <= qdac_chan_e'(word_next[`QDAC_SEL_HI_BIT:`QDAC_SEL_LO_BIT]);
            end
        end
    end

    // Word counters for software
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            acc_cnt_reg <= '0;
            rej_cnt_reg <= '0;
        end
        else if (word_done)
        begin
            if (addr_match)
                acc_cnt_reg <= acc_cnt_reg + 16'h1;
            else
                rej_cnt_reg <= rej_cnt_reg + 16'h1;
        end
    end

    // The link cannot stall, so a word that meets a full FIFO is lost and flagged
    assign strm.push_valid = acc_valid_reg;
    assign strm.push_data  = acc_word_reg;
    assign strm.pop_ready  = ~ctrl_reg[`QDAC_CTRL_HOLD_BIT];
    assign pop_word        = qdac_word_s'(strm.pop_data);

    qdac_fifo #(.W($bits(qdac_word_s)), .DEPTH(FIFO_DEPTH)) u_fifo
    (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .s     (strm)
    );

    // Overflow flag; a new loss beats a clear in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ovf_reg <= 1'b0;
        else if (acc_valid_reg && !strm.push_ready)
            ovf_reg <= 1'b1;
        else if (ovf_clr)
            ovf_reg <= 1'b0;
    end

    // Input latches take drained words; clear never touches them
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < NCH; i++)
                inl_reg[i] <= '0;
        end
        else if (strm.pop_valid && strm.pop_ready)
            inl_reg[pop_word.chan] <= pop_word.code;
    end

    // Converter latches: clear wins over load
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !clr_n_s)
        begin
            for (int i = 0; i < NCH; i++)
                dacl_reg[i] <= '0;
        end
        else if (load_fall)
        begin
            for (int i = 0; i < NCH; i++)
                dacl_reg[i] <= inl_reg[i];
        end
    end

    // Switch decode, registered so the pins change together
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            code_reg   <= '0;
            seg_reg    <= '0;
            ladder_reg <= '0;
        end
        else
        begin
            for (int i = 0; i < NCH; i++)
            begin
                code_reg[i*12 +: 12]  <= dacl_reg[i];
                ladder_reg[i*10 +: 10] <= dacl_reg[i][9:0];
                for (int k = 0; k < `QDAC_SEG_BITS; k++)
                    seg_reg[i*3 + k] <= (dacl_reg[i][11:10] > 2'(k));
            end
        end
    end

    assign dac_code_o      = code_reg;
    assign seg_switch_o    = seg_reg;
    assign ladder_switch_o = ladder_reg;

    // Write channel: address and data caught in either order
    assign s_axi_awready = ~aw_got_reg & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_got_reg & ~s_axi_bvalid;
    assign wr_do         = aw_got_reg & w_got_reg & ~s_axi_bvalid;
    assign wr_hit        = (aw_addr_reg[ADDR_W-1:2] == IX_CTRL)
                        || (aw_addr_reg[ADDR_W-1:2] == IX_STAT);
    assign ovf_clr       = wr_do && w_strb_reg[0]
                        && (aw_addr_reg[ADDR_W-1:2] == IX_STAT)
                        && w_data_reg[`QDAC_STAT_OVF_BIT];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            aw_got_reg  <= 1'b0;
            w_got_reg   <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg  <= '0;
            w_strb_reg  <= '0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_reg  <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            else if (wr_do)
                aw_got_reg <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_reg  <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            else if (wr_do)
                w_got_reg <= 1'b0;
        end
    end

    // Write response
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `QDAC_RESP_OKAY;
        end
        else if (wr_do)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `QDAC_RESP_OKAY : `QDAC_RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Control register, byte lanes honoured
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ctrl_reg <= `QDAC_CTRL_RST;
        else if (wr_do && (aw_addr_reg[ADDR_W-1:2] == IX_CTRL))
        begin
            for (int b = 0; b < 4; b++)
                if (w_strb_reg[b])
                    ctrl_reg[b*8 +: 8] <= w_data_reg[b*8 +: 8];
        end
    end

    // Read decode
    always_comb
    begin
        rd_data = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (s_axi_araddr[ADDR_W-1:2])
            IX_CTRL:
                rd_data = ctrl_reg;
            IX_STAT:
            begin
                rd_data[`QDAC_STAT_OVF_BIT]   = ovf_reg;
                rd_data[`QDAC_STAT_FRAME_BIT] = ~frame_n_s;
                rd_data[`QDAC_STAT_EMPTY_BIT] = ~strm.pop_valid;
                rd_data[`QDAC_STAT_FULL_BIT]  = ~strm.push_ready;
                rd_data[`QDAC_STAT_ALO_BIT]   = strap_lo_s;
                rd_data[`QDAC_STAT_AHI_BIT]   = strap_hi_s;
                rd_data[`QDAC_STAT_CLR_BIT]   = ~clr_n_s;
            end
            IX_WORDS:
                rd_data = {rej_cnt_reg, acc_cnt_reg};
            default:
            begin
                rd_hit = 1'b0;
                for (int i = 0; i < NCH; i++)
                begin
                    if (s_axi_araddr[ADDR_W-1:2] == IX_INL + (ADDR_W-2)'(i))
                    begin
                        rd_data = {20'h00000, inl_reg[i]};
                        rd_hit  = 1'b1;
                    end
                    if (s_axi_araddr[ADDR_W-1:2] == IX_DACL + (ADDR_W-2)'(i))
                    begin
                        rd_data = {20'h00000, dacl_reg[i]};
                        rd_hit  = 1'b1;
                    end
                end
            end
        endcase
    end

    // Read answer one cycle after the address is taken
    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= `QDAC_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_data;
            s_axi_rresp  <= rd_hit ? `QDAC_RESP_OKAY : `QDAC_RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

endmodule

// file: design/qdac_sync.sv
`timescale 1ns/1ns
module qdac_sync #(parameter int W = 1)
(
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Asynchronous in, synchronous out
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    // Two flops; only the second stage reaches logic
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;

endmodule

// file: include/qdac_params.svh
`ifndef QDAC_PARAMS_SVH
`define QDAC_PARAMS_SVH

// Register byte offsets on the AXI4-Lite slave
`define QDAC_OFS_CTRL      8'h00
`define QDAC_OFS_STATUS    8'h04
`define QDAC_OFS_WORDS     8'h08
`define QDAC_OFS_INL_BASE  8'h10
`define QDAC_OFS_DACL_BASE 8'h20

// Control register fields and reset value
`define QDAC_CTRL_LISTEN_BIT 0
`define QDAC_CTRL_HOLD_BIT   1
`define QDAC_CTRL_RST        32'h0000_0001

// Status register fields
`define QDAC_STAT_OVF_BIT    0
`define QDAC_STAT_FRAME_BIT  1
`define QDAC_STAT_EMPTY_BIT  2
`define QDAC_STAT_FULL_BIT   3
`define QDAC_STAT_ALO_BIT    4
`define QDAC_STAT_AHI_BIT    5
`define QDAC_STAT_CLR_BIT    8

// Serial word layout
`define QDAC_WORD_BITS   16
`define QDAC_CODE_MSB    15
`define QDAC_CODE_LSB    4
`define QDAC_ADDR_HI_BIT 3
`define QDAC_ADDR_LO_BIT 2
`define QDAC_SEL_HI_BIT  1
`define QDAC_SEL_LO_BIT  0

// Converter layout
`define QDAC_NUM_CH      4
`define QDAC_CODE_BITS   12
`define QDAC_LADDER_BITS 10
`define QDAC_SEG_BITS    3
`define QDAC_FIFO_DEPTH  8

// AXI answers
`define QDAC_RESP_OKAY   2'h0
`define QDAC_RESP_SLVERR 2'h2

`endif

// file: include/qdac_pkg.sv
package qdac_pkg;

    // One converter code
    typedef logic [11:0] qdac_code_t;

    // Input latch selection carried in the low word bits
    typedef enum logic [1:0]
    {
        QDAC_CH_A = 2'b00,
        QDAC_CH_B = 2'b01,
        QDAC_CH_C = 2'b10,
        QDAC_CH_D = 2'b11
    } qdac_chan_e;

    // Accepted word on its way to the input latches
    typedef struct packed
    {
        qdac_code_t code;
        qdac_chan_e chan;
    } qdac_word_s;

endpackage

// file: include/qdac_stream_if.sv
`timescale 1ns/1ns
interface qdac_stream_if #(parameter int W = 14);
    logic         push_valid;
    logic         push_ready;
    logic [W-1:0] push_data;
    logic         pop_valid;
    logic         pop_ready;
    logic [W-1:0] pop_data;

    modport fifo (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data);
    modport user (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data);
endinterface

// file: verif/qdac_host_model.sv
`timescale 1ns/1ns
module qdac_host_model
(
    // Link pins toward the device
    output logic        frame_sync_n_o,
    output logic        serial_clk_o,
    output logic        serial_data_o,
    // Daisy output and what it carried
    input  wire logic   serial_echo_i,
    output logic [15:0] echo_o
);
    // Idle link: clock parked low as its pull-down leaves it
    initial
    begin
        frame_sync_n_o = 1'b1;
        serial_clk_o   = 1'b0;
        serial_data_o  = 1'b0;
        echo_o         = 16'h0000;
    end

    // First n bits of w; more keeps the frame open for a chained word
    task send(input logic [15:0] w, input int n, input bit more);
        int i;
        frame_sync_n_o <= 1'b0;
        #40;
        // Data moves on the rising edge so it stands still around each falling edge
        for (i = 15; i > 15 - n; i--)
        begin
            #62 serial_clk_o <= 1'b1;
            serial_data_o <= w[i];
            echo_o <= {echo_o[14:0], serial_echo_i};
            #63 serial_clk_o <= 1'b0;
        end
        #62 frame_sync_n_o <= !more;
        serial_data_o <= more ? serial_data_o : ~serial_data_o;
        // Idle gap so back-to-back frames are seen as separate
        #40;
    endtask
endmodule

// file: verif/qdac_serial_load_assertions.sv
`timescale 1ns/1ns
module qdac_chk
(
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // Bus answers
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    // Link and latch pins
    input wire logic        frame_sync_n_i,
    input wire logic        serial_clk_in_i,
    input wire logic        serial_data_out_o,
    input wire logic        load_all_outputs_n_i,
    input wire logic        zero_outputs_n_i,
    // Converter drive
    input wire logic [47:0] dac_code_o,
    input wire logic [11:0] seg_switch_o,
    input wire logic [39:0] ladder_switch_o
);
    logic [3:0] shift_age_reg;
    logic [3:0] ctl_age_reg;

    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Cycles since a frame start or in-frame fall; the shifter may move only then
    always_ff @(posedge clk_i)
    begin
        if (rst_i || $fell(frame_sync_n_i) || ($fell(serial_clk_in_i) && !frame_sync_n_i))
            shift_age_reg <= 4'h0;
        else if (shift_age_reg != 4'hF)
            shift_age_reg <= shift_age_reg + 4'h1;
    end

    // Cycles since a load edge or a low clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i || $fell(load_all_outputs_n_i) || !zero_outputs_n_i)
            ctl_age_reg <= 4'h0;
        else if (ctl_age_reg != 4'hF)
            ctl_age_reg <= ctl_age_reg + 4'h1;
    end

    property p_ladder; ladder_switch_o == {dac_code_o[45:36], dac_code_o[33:24], dac_code_o[21:12], dac_code_o[9:0]};
    endproperty
    a_ladder: assert property (p_ladder) else $error("ladder drive off");
    property p_seg; seg_switch_o[2:0] == {dac_code_o[11:10] == 2'h3, dac_code_o[11], |dac_code_o[11:10]}; endproperty
    a_seg: assert property (p_seg) else $error("segment drive off");
    property p_clr; !zero_outputs_n_i [*8] |-> dac_code_o == 48'h0; endproperty
    a_clr: assert property (p_clr) else $error("clear not zeroing");
    property p_sdo; $changed(serial_data_out_o) |-> shift_age_reg <= 4'h8; endproperty
    a_sdo: assert property (p_sdo) else $error("serial out moved alone");
    property p_code; $changed(dac_code_o) |-> ctl_age_reg <= 4'h8; endproperty
    a_code: assert property (p_code) else $error("code moved alone");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read answer dropped");
    property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rans: assert property (p_rans) else $error("read answer late");
endmodule

bind qdac_serial_load qdac_chk u_qdac_chk (.clk_i, .rst_i, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .frame_sync_n_i, .serial_clk_in_i,
    .serial_data_out_o, .load_all_outputs_n_i, .zero_outputs_n_i, .dac_code_o, .seg_switch_o, .ladder_switch_o);

// file: verif/tb.sv
`timescale 1ns/1ns
`include "qdac_params.svh"
module tb;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        load_all_outputs_n_i = 1'b1, zero_outputs_n_i = 1'b1;
    logic        addr_strap_lo_i = 1'b0, addr_strap_hi_i = 1'b1;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, serial_data_out_o;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [47:0] dac_code_o;
    logic [11:0] seg_switch_o;
    logic [39:0] ladder_switch_o;
    logic [15:0] echo;
    wire         frame_sync_n_i, serial_clk_in_i, serial_data_in_i;
    logic [11:0] codes [4] = '{12'h3FF, 12'h400, 12'h800, 12'hFFF};
    int          failures = 0, comparisons = 0;

    qdac_serial_load u_qdac_serial_load (.clk_i, .rst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .frame_sync_n_i, .serial_clk_in_i, .serial_data_in_i, .serial_data_out_o, .load_all_outputs_n_i,
        .zero_outputs_n_i, .addr_strap_lo_i, .addr_strap_hi_i, .dac_code_o, .seg_switch_o, .ladder_switch_o);
    qdac_host_model u_qdac_host_model (.frame_sync_n_o(frame_sync_n_i), .serial_clk_o(serial_clk_in_i),
        .serial_data_o(serial_data_in_i), .serial_echo_i(serial_data_out_o), .echo_o(echo));

    // 250 MHz core clock
    always #2 clk_i = ~clk_i;

    task chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task print_verdict;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // A hung handshake ends the run
    task tmo(input int n);
        if (n == 50)
        begin
            failures++;
            print_verdict();
        end
    endtask

    // Bus write; bready trails bvalid a cycle so the slave must hold its answer
    task axw(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] rs);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= wd;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk_i);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready)
                break;
            s_axi_bready <= s_axi_bvalid;
        end
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        tmo(n);
    endtask

    // Bus read, same late-ready habit
    task axr(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] rs);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk_i);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready)
                break;
            s_axi_rready <= s_axi_rvalid;
        end
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        tmo(n);
    endtask

    // Load pulse, then time for sync and output stages
    task pulse_load;
        load_all_outputs_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        load_all_outputs_n_i <= 1'b1;
        repeat (10) @(posedge clk_i);
    endtask

    // Main sequence
    initial
    begin
        logic [31:0] d;
        logic [1:0]  r;
        int          c;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        axr(`QDAC_OFS_CTRL, d, r);
        chk("ctrl reset", d, `QDAC_CTRL_RST);
        axr(8'h40, d, r);
        chk("unmapped read", r, `QDAC_RESP_SLVERR);
        axw(`QDAC_OFS_WORDS, 32'h1, r);
        chk("read-only write", r, `QDAC_RESP_SLVERR);
        $display("register test done");
        for (c = 0; c < 4; c++)
        begin
            u_qdac_host_model.send({codes[c], 2'b10, c[1:0]}, 16, 1'b0);
            repeat (10) @(posedge clk_i);
            axr(8'h10 + 8'(4 * c), d, r);
            chk("input latch", d, codes[c]);
        end
        chk("code before load", dac_code_o, 48'h0);
        u_qdac_host_model.send({12'h123, 2'b01, 2'b00}, 16, 1'b0);
        u_qdac_host_model.send({12'h456, 2'b10, 2'b01}, 10, 1'b0);
        u_qdac_host_model.send({12'hABC, 2'b00, 2'b10}, 16, 1'b1);
        u_qdac_host_model.send(16'h5A51, 16, 1'b0);
        repeat (10) @(posedge clk_i);
        chk("daisy echo", echo, {12'hABC, 2'b00, 2'b10});
        for (c = 0; c < 3; c++)
        begin
            axr(8'h10 + 8'(4 * c), d, r);
            chk("latch kept", d, codes[c]);
        end
        axr(`QDAC_OFS_WORDS, d, r);
        chk("word counts", d, 32'h0002_0004);
        $display("link test done");
        pulse_load();
        chk("codes", dac_code_o, {codes[3], codes[2], codes[1], codes[0]});
        chk("segments", seg_switch_o, 12'hEC8);
        chk("ladder", ladder_switch_o, {10'h3FF, 20'h0, 10'h3FF});
        zero_outputs_n_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        chk("cleared", dac_code_o, 48'h0);
        axr(8'h1C, d, r);
        chk("latch after clear", d, codes[3]);
        zero_outputs_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        pulse_load();
        chk("restored", dac_code_o, {codes[3], codes[2], codes[1], codes[0]});
        $display("latch test done");
        print_verdict();
    end
endmodule
